// file: verilog/cmc_pkg.sv
// cmc_pkg: geometry, encodings and register map of the sectored cache.
// assumes the address split word[4:2], sector[5], index[11:6], tag[31:12].
package cmc_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int CMC_CACHE_BYTES = 32768;
  localparam int CMC_WAYS = 8;
  localparam int CMC_SETS = 64;
  localparam int CMC_SEC_WORDS = 8;
  localparam int CMC_LINE_WORDS = 16;
  localparam int CMC_QW_BIT = 4;
  localparam int CMC_SEC_BIT = 5;
  localparam int CMC_IDX_LSB = 6;
  localparam int CMC_TAG_LSB = 12;
  localparam int CMC_TAG_W = 20;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  typedef enum logic [1:0] {MESI_I = 2'h0, MESI_S = 2'h1, MESI_E = 2'h2, MESI_M = 2'h3} cmc_mesi_e;
  typedef enum logic [1:0] {BUS_RD = 2'h0, BUS_RWITM = 2'h1, BUS_WR = 2'h2} cmc_bus_cmd_e;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [4:0] CMC_REG_CTRL = 5'h00;
  localparam logic [4:0] CMC_REG_STATUS = 5'h04;
  localparam logic [4:0] CMC_REG_HITS = 5'h08;
  localparam logic [4:0] CMC_REG_MISSES = 5'h0c;
  localparam int CMC_CTRL_NOCOMP = 0;
  localparam logic CMC_CTRL_RST = 1'h0;
  localparam logic [1:0] CMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMC_RESP_SLVERR = 2'h2;
endpackage

// file: verilog/cmc_cache.sv
// cmc_cache: unified sectored MESI cache with snoop port and AXI4-Lite regs.
// assumes a bus partner that returns quad-word beats on bus_ack, in order.
`timescale 1ns/1ns
module cmc_cache import cmc_pkg::*; #(
  parameter int WAYS = CMC_WAYS,
  parameter int SETS = CMC_SETS
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic cpu_req, // access request, held until cpu_ready
  input wire logic cpu_we, // store when high
  input wire logic [31:0] cpu_addr, // physical byte address
  input wire logic [31:0] cpu_wdata, // store word
  input wire logic cpu_wt, // region is write-through
  input wire logic cpu_ci, // region is cache-inhibited
  input wire logic cpu_coh, // region requires coherency
  output logic cpu_ready, // request accepted this cycle
  output logic cpu_rvalid, // load word valid
  output logic [31:0] cpu_rdata, // load word
  output logic bus_req, // bus transfer in progress
  output logic [1:0] bus_cmd, // read, read-with-intent, write
  output logic [31:0] bus_addr, // beat address
  output logic [127:0] bus_wdata, // write beat
  input wire logic bus_ack, // beat completes
  input wire logic [127:0] bus_rdata, // read beat
  input wire logic bus_shared, // another cache keeps a copy
  input wire logic snp_valid, // snooped transaction present
  input wire logic [31:0] snp_addr, // snooped address
  input wire logic snp_inv, // snooped transaction takes ownership
  output logic snp_ready, // snoop taken
  output logic snp_hit, // last snoop hit
  output logic snp_dirty, // last snoop hit a modified sector
  input wire logic s_axi_awvalid, // axi write address valid
  output logic s_axi_awready, // axi write address ready
  input wire logic [4:0] s_axi_awaddr, // axi write address
  input wire logic s_axi_wvalid, // axi write data valid
  output logic s_axi_wready, // axi write data ready
  input wire logic [31:0] s_axi_wdata, // axi write data
  input wire logic [3:0] s_axi_wstrb, // axi byte strobes
  output logic s_axi_bvalid, // axi write response valid
  input wire logic s_axi_bready, // axi write response ready
  output logic [1:0] s_axi_bresp, // axi write response
  input wire logic s_axi_arvalid, // axi read address valid
  output logic s_axi_arready, // axi read address ready
  input wire logic [4:0] s_axi_araddr, // axi read address
  output logic s_axi_rvalid, // axi read data valid
  input wire logic s_axi_rready, // axi read data ready
  output logic [31:0] s_axi_rdata, // axi read data
  output logic [1:0] s_axi_rresp // axi read response
);
  localparam int WB = $clog2(WAYS);
  localparam int IW = CMC_TAG_LSB - CMC_IDX_LSB;
  typedef enum logic [2:0] {ST_IDLE, ST_WB, ST_FILL, ST_COMP, ST_UNC} cmc_state_e;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [CMC_TAG_W-1:0] tag_q [SETS][WAYS];
  cmc_mesi_e st_q [SETS][WAYS][2];
  logic [WB-1:0] age_q [SETS][WAYS];
  logic [31:0] dat_q [SETS][WAYS][CMC_LINE_WORDS];

  function automatic logic [IW-1:0] f_idx(input logic [31:0] a);
    return a[CMC_TAG_LSB-1:CMC_IDX_LSB];
  endfunction

  function automatic logic [CMC_TAG_W-1:0] f_tag(input logic [31:0] a);
    return a[31:CMC_TAG_LSB];
  endfunction

  // tag match on a line holding at least one valid sector
  function automatic logic [WB:0] f_find(input logic [31:0] a);
    logic [WB:0] r;
    r = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (tag_q[f_idx(a)][w] == f_tag(a) &&
          (st_q[f_idx(a)][w][0] != MESI_I || st_q[f_idx(a)][w][1] != MESI_I)) begin
        r = {1'b1, WB'(w)};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] f_word(input logic [127:0] q, input logic [1:0] s);
    return q[32*s +: 32];
  endfunction

  // ----------------------------------------
  // lookup
  // ----------------------------------------
  cmc_state_e state_q;
  logic [31:0] ra_q, rwd_q;
  logic rwe_q, rwt_q, rcoh_q, snpwb_q, nl_q, beat_q;
  logic [WB-1:0] rway_q;
  logic [1:0] wbm_q;
  logic nocomp_q;
  logic [WB:0] c_find, s_find;
  logic [WB-1:0] c_way, s_way, lru_way;
  cmc_mesi_e c_st, s_st;
  logic c_hit, s_hit, snp_go, cpu_go, hit_ok, to_unc, to_fill, alloc;
  logic wb_last, last, cur_sec, cur_qw, comp_ok, vic_dirty;
  logic [IW-1:0] ridx;
  logic [127:0] fill_d;

  assign c_find = f_find(cpu_addr);
  assign s_find = f_find(snp_addr);
  assign c_way = c_find[WB-1:0];
  assign s_way = s_find[WB-1:0];
  assign c_st = st_q[f_idx(cpu_addr)][c_way][cpu_addr[CMC_SEC_BIT]];
  assign s_st = st_q[f_idx(snp_addr)][s_way][snp_addr[CMC_SEC_BIT]];
  assign c_hit = c_find[WB] && c_st != MESI_I;
  assign s_hit = s_find[WB] && s_st != MESI_I;
  assign snp_go = snp_valid && s_hit && state_q == ST_IDLE;
  assign snp_ready = snp_valid && (!s_hit || state_q == ST_IDLE);
  assign cpu_go = state_q == ST_IDLE && cpu_req && !snp_go;
  // shared store hits go out on the bus so other copies are dropped
  assign hit_ok = cpu_go && !cpu_ci && c_hit &&
                  !(cpu_we && (cpu_wt || c_st == MESI_S));
  assign to_unc = cpu_go && !hit_ok && (cpu_ci || (cpu_we && (cpu_wt || c_hit)));
  assign to_fill = cpu_go && !hit_ok && !to_unc;

  always_comb begin
    lru_way = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (age_q[f_idx(cpu_addr)][w] == WB'(WAYS - 1)) begin
        lru_way = WB'(w);
      end
    end
  end

  assign ridx = f_idx(ra_q);
  assign vic_dirty = st_q[f_idx(cpu_addr)][lru_way][0] == MESI_M ||
                     st_q[f_idx(cpu_addr)][lru_way][1] == MESI_M;
  assign cur_sec = state_q == ST_WB ? wbm_q[0] :
                   state_q == ST_COMP ? !ra_q[CMC_SEC_BIT] : ra_q[CMC_SEC_BIT];
  assign cur_qw = state_q == ST_FILL ? ra_q[CMC_QW_BIT] ^ beat_q : beat_q;
  assign last = beat_q || state_q == ST_UNC;
  // a dirty victim keeps its tag until its last writeback beat
  assign wb_last = state_q == ST_WB && bus_ack && beat_q &&
                   (wbm_q == 2'b10 || wbm_q == 2'b01);
  assign alloc = (to_fill && !c_find[WB] && !vic_dirty) || (wb_last && nl_q && !snpwb_q);
  assign comp_ok = !nocomp_q && st_q[ridx][rway_q][!ra_q[CMC_SEC_BIT]] == MESI_I &&
                   !cpu_req;

  // store data merged into the critical quad word
  always_comb begin
    fill_d = bus_rdata;
    if (state_q == ST_FILL && rwe_q && !beat_q) begin
      fill_d[32*ra_q[3:2] +: 32] = rwd_q;
    end
  end

  // ----------------------------------------
  // bus side
  // ----------------------------------------
  assign bus_req = state_q != ST_IDLE;
  assign bus_cmd = (state_q == ST_WB || (state_q == ST_UNC && rwe_q)) ? BUS_WR :
                   (state_q == ST_FILL && rwe_q) ? BUS_RWITM : BUS_RD;
  assign bus_addr = state_q == ST_UNC ? ra_q :
                    {tag_q[ridx][rway_q], ridx, cur_sec, cur_qw, 4'h0};
  always_comb begin
    bus_wdata = {4{rwd_q}};
    if (state_q == ST_WB) begin
      for (int k = 0; k < 4; k++) begin
        bus_wdata[32*k +: 32] = dat_q[ridx][rway_q][{cur_sec, cur_qw, 2'(k)}];
      end
    end
  end
  assign cpu_ready = hit_ok || (state_q == ST_FILL && bus_ack && !beat_q) ||
                     (state_q == ST_UNC && bus_ack);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      ra_q <= 32'h0;
      rwd_q <= 32'h0;
      rwe_q <= 1'b0;
      rwt_q <= 1'b0;
      rcoh_q <= 1'b0;
      rway_q <= '0;
      wbm_q <= 2'b00;
      snpwb_q <= 1'b0;
      nl_q <= 1'b0;
      beat_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          beat_q <= 1'b0;
          if (snp_go && s_st == MESI_M) begin
            state_q <= ST_WB;
            ra_q <= snp_addr;
            rway_q <= s_way;
            wbm_q <= snp_addr[CMC_SEC_BIT] ? 2'b01 : 2'b10;
            snpwb_q <= 1'b1;
          end else if (cpu_go && !hit_ok) begin
            ra_q <= cpu_addr;
            rwd_q <= cpu_wdata;
            rwe_q <= cpu_we;
            rwt_q <= cpu_wt;
            rcoh_q <= cpu_coh;
            snpwb_q <= 1'b0;
            nl_q <= !c_find[WB];
            if (to_unc) begin
              state_q <= ST_UNC;
            end else if (c_find[WB]) begin
              state_q <= ST_FILL;
              rway_q <= c_way;
            end else begin
              rway_q <= lru_way;
              wbm_q <= {st_q[f_idx(cpu_addr)][lru_way][1] != MESI_M,
                        st_q[f_idx(cpu_addr)][lru_way][0] != MESI_M};
              if (st_q[f_idx(cpu_addr)][lru_way][0] == MESI_M ||
                  st_q[f_idx(cpu_addr)][lru_way][1] == MESI_M) begin
                state_q <= ST_WB;
              end else begin
                state_q <= ST_FILL;
              end
            end
          end
        end
        ST_WB: begin
          if (bus_ack) begin
            beat_q <= !beat_q;
            if (beat_q) begin
              wbm_q <= wbm_q[0] ? 2'b11 : {wbm_q[1], 1'b1};
              if (wbm_q != 2'b10 && wbm_q != 2'b01) begin
                state_q <= state_q;
              end else if (snpwb_q) begin
                state_q <= ST_IDLE;
              end else begin
                state_q <= ST_FILL;
              end
            end
          end
        end
        ST_FILL: begin
          if (bus_ack) begin
            beat_q <= !beat_q;
            if (last) begin
              state_q <= comp_ok ? ST_COMP : ST_IDLE;
            end
          end
        end
        ST_COMP, ST_UNC: begin
          if (bus_ack) begin
            beat_q <= !beat_q;
            if (last) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // arrays: tags, states, ages, data
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < SETS; s++) begin
        for (int w = 0; w < WAYS; w++) begin
          st_q[s][w][0] <= MESI_I;
          st_q[s][w][1] <= MESI_I;
          age_q[s][w] <= WB'(w);
        end
      end
    end else begin
      if (hit_ok || alloc) begin
        for (int w = 0; w < WAYS; w++) begin
          if (WB'(w) == (hit_ok ? c_way : (to_fill ? lru_way : rway_q))) begin
            age_q[hit_ok || to_fill ? f_idx(cpu_addr) : ridx][w] <= '0;
          end else if (age_q[hit_ok || to_fill ? f_idx(cpu_addr) : ridx][w] <
                       age_q[hit_ok || to_fill ? f_idx(cpu_addr) : ridx]
                            [hit_ok ? c_way : (to_fill ? lru_way : rway_q)]) begin
            age_q[hit_ok || to_fill ? f_idx(cpu_addr) : ridx][w] <=
              age_q[hit_ok || to_fill ? f_idx(cpu_addr) : ridx][w] + WB'(1);
          end
        end
      end
      if (cpu_go && cpu_we && c_hit && !cpu_ci) begin
        dat_q[f_idx(cpu_addr)][c_way][cpu_addr[CMC_SEC_BIT:2]] <= cpu_wdata;
        if (hit_ok) begin
          st_q[f_idx(cpu_addr)][c_way][cpu_addr[CMC_SEC_BIT]] <= MESI_M;
        end
      end
      if (alloc) begin
        tag_q[to_fill ? f_idx(cpu_addr) : ridx][to_fill ? lru_way : rway_q] <=
          to_fill ? f_tag(cpu_addr) : f_tag(ra_q);
        st_q[to_fill ? f_idx(cpu_addr) : ridx][to_fill ? lru_way : rway_q][0] <= MESI_I;
        st_q[to_fill ? f_idx(cpu_addr) : ridx][to_fill ? lru_way : rway_q][1] <= MESI_I;
      end
      if (snp_go) begin
        st_q[f_idx(snp_addr)][s_way][snp_addr[CMC_SEC_BIT]] <=
          snp_inv ? MESI_I : MESI_S;
      end
      if ((state_q == ST_FILL || state_q == ST_COMP) && bus_ack) begin
        for (int k = 0; k < 4; k++) begin
          dat_q[ridx][rway_q][{cur_sec, cur_qw, 2'(k)}] <= fill_d[32*k +: 32];
        end
        if (last) begin
          if (state_q == ST_FILL && rwe_q) begin
            st_q[ridx][rway_q][cur_sec] <= MESI_M;
          end else begin
            st_q[ridx][rway_q][cur_sec] <= rcoh_q && bus_shared ? MESI_S : MESI_E;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // processor and snoop answers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_rvalid <= 1'b0;
      cpu_rdata <= 32'h0;
      snp_hit <= 1'b0;
      snp_dirty <= 1'b0;
    end else begin
      cpu_rvalid <= cpu_ready && (hit_ok ? !cpu_we : !rwe_q);
      if (hit_ok) begin
        cpu_rdata <= dat_q[f_idx(cpu_addr)][c_way][cpu_addr[CMC_SEC_BIT:2]];
      end else if (cpu_ready) begin
        cpu_rdata <= f_word(bus_rdata, ra_q[3:2]);
      end
      if (snp_ready) begin
        snp_hit <= s_hit;
        snp_dirty <= s_hit && s_st == MESI_M;
      end
    end
  end

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  logic aw_q, w_q;
  logic [4:0] awa_q;
  logic [31:0] wd_q, hits_q, miss_q;
  logic [3:0] ws_q;
  logic [31:0] rd_d;
  logic [1:0] rr_d;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rr_d = CMC_RESP_OKAY;
    case (s_axi_araddr)
      CMC_REG_CTRL: rd_d = {31'h0, nocomp_q};
      CMC_REG_STATUS: rd_d = {29'h0, state_q};
      CMC_REG_HITS: rd_d = hits_q;
      CMC_REG_MISSES: rd_d = miss_q;
      default: begin
        rd_d = 32'h0;
        rr_d = CMC_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 5'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      nocomp_q <= CMC_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CMC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= CMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awa_q[4] || awa_q[1:0] != 2'h0 ? CMC_RESP_SLVERR : CMC_RESP_OKAY;
        if (awa_q == CMC_REG_CTRL && ws_q[0]) begin
          nocomp_q <= wd_q[CMC_CTRL_NOCOMP];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rr_d;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hits_q <= 32'h0;
      miss_q <= 32'h0;
    end else if (cpu_go && !cpu_ci) begin
      if (c_hit) begin
        hits_q <= hits_q + 32'h1;
      end else begin
        miss_q <= miss_q + 32'h1;
      end
    end
  end
endmodule

// file: verification/cmc_cache_properties.sv
// cmc_cache_properties: port-level checks of the sectored cache.
// assumes it is bound onto cmc_cache and sees only its ports.
`timescale 1ns/1ns
module cmc_cache_chk import cmc_pkg::*; (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic cpu_req, // request
  input wire logic cpu_we, // store
  input wire logic [31:0] cpu_addr, // address
  input wire logic [31:0] cpu_wdata, // store word
  input wire logic cpu_wt, // write-through
  input wire logic cpu_ci, // inhibited
  input wire logic cpu_ready, // taken
  input wire logic cpu_rvalid, // load valid
  input wire logic [31:0] cpu_rdata, // load word
  input wire logic bus_req, // beat pending
  input wire logic [1:0] bus_cmd, // command
  input wire logic [31:0] bus_addr, // beat address
  input wire logic [127:0] bus_wdata, // write beat
  input wire logic bus_ack, // beat done
  input wire logic [127:0] bus_rdata, // read beat
  input wire logic snp_valid, // snoop
  input wire logic [31:0] snp_addr, // snoop address
  input wire logic snp_ready, // snoop taken
  input wire logic snp_hit, // snoop hit
  input wire logic snp_dirty // snoop dirty
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [31:0] ba_q;
  logic [31:0] sa_q;
  logic [31:0] fwd;
  assign fwd = bus_rdata[32*cpu_addr[3:2] +: 32];
  always_ff @(posedge aclk) begin
    ba_q <= bus_addr;
    sa_q <= snp_addr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_crit;
    cpu_req && cpu_ready && bus_ack && !cpu_ci && bus_cmd != BUS_WR;
  endsequence
  sequence s_snp;
    snp_valid && snp_ready;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_load_answer: assert property (cpu_req && cpu_ready && !cpu_we |=> cpu_rvalid)
    else $error("load not answered");
  a_crit_first: assert property (s_crit |-> bus_addr[31:4] == cpu_addr[31:4])
    else $error("fill did not start at the missed quad");
  a_crit_fwd: assert property (s_crit ##0 !cpu_we |=> cpu_rdata == $past(fwd))
    else $error("critical word not forwarded");
  a_rest_next: assert property (s_crit |=> bus_req &&
    bus_addr == {ba_q[31:5], ~ba_q[4], 4'h0}) else $error("second beat wrong");
  a_beat_hold: assert property (bus_req && !bus_ack |=>
    bus_req && $stable(bus_addr) && $stable(bus_cmd)) else $error("beat not held");
  a_inhib_direct: assert property (cpu_req && cpu_ci && cpu_ready |->
    bus_ack && bus_addr == cpu_addr) else $error("inhibited access not on bus");
  a_wt_store: assert property (cpu_req && cpu_we && cpu_wt && !cpu_ci && cpu_ready |->
    bus_ack && bus_cmd == BUS_WR && bus_wdata[31:0] == cpu_wdata) else $error("wt store");
  a_snoop_nostall: assert property (s_snp ##0 cpu_req && cpu_ready |=> !snp_hit)
    else $error("cpu served during snoop hit");
  a_dirty_wb: assert property (s_snp ##1 snp_dirty |-> bus_req &&
    bus_cmd == BUS_WR && bus_addr[31:5] == sa_q[31:5]) else $error("no writeback");
  a_dirty_hit: assert property (snp_dirty |-> snp_hit)
    else $error("dirty without hit");
endmodule
bind cmc_cache cmc_cache_chk cmc_cache_chk_inst (.aclk, .aresetn, .cpu_req, .cpu_we,
  .cpu_addr, .cpu_wdata, .cpu_wt, .cpu_ci, .cpu_ready, .cpu_rvalid, .cpu_rdata, .bus_req,
  .bus_cmd, .bus_addr, .bus_wdata, .bus_ack, .bus_rdata, .snp_valid, .snp_addr, .snp_ready,
  .snp_hit, .snp_dirty);

// file: verification/cmc_bus_mem.sv
// cmc_bus_mem: behavioural system bus and memory behind the cache.
// assumes one beat at a time; dly sets the wait before each ack.
`timescale 1ns/1ns
module cmc_bus_mem import cmc_pkg::*; (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic bus_req, // beat pending
  input wire logic [1:0] bus_cmd, // command
  input wire logic [31:0] bus_addr, // beat address
  input wire logic [127:0] bus_wdata, // write beat
  input wire logic [3:0] dly, // wait cycles
  input wire logic sh_in, // another copy exists
  output logic bus_ack, // beat done
  output logic [127:0] bus_rdata, // read beat
  output logic bus_shared // shared copy
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0] cnt_q;
  logic [31:0] qa;
  initial bus_rdata = 128'h0;
  function automatic logic [31:0] rd(logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'hc3c30000;
  endfunction
  assign qa = {bus_addr[31:4], 4'h0};
  // idle data toggles so stale beats never look valid
  always @(posedge aclk) begin
    bus_shared <= sh_in;
    if (!aresetn || !bus_req || bus_ack) begin
      cnt_q <= 4'h0;
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end else if (cnt_q < dly) begin
      cnt_q <= cnt_q + 4'h1;
      bus_rdata <= ~bus_rdata;
    end else begin
      bus_ack <= 1'b1;
      for (int k = 0; k < 4; k++) bus_rdata[32*k +: 32] <= rd(qa + 32'(4*k));
    end
  end
  // replicated lanes mark a single-word write
  always @(posedge aclk) begin
    if (bus_ack && bus_req && bus_cmd == BUS_WR) begin
      for (int k = 0; k < 4; k++) begin
        if (bus_wdata != {4{bus_wdata[31:0]}} || k == int'(bus_addr[3:2])) begin
          mem[qa + 32'(4*k)] = bus_wdata[32*k +: 32];
        end
      end
    end
  end
endmodule

// file: verification/test_unified_sectored_mesi_cache.sv
// test_unified_sectored_mesi_cache: directed checks of the sectored cache.
// assumes cmc_bus_mem as bus partner and the bound port checker.
`timescale 1ns/1ns
module test_unified_sectored_mesi_cache import cmc_pkg::*; ();
  logic aclk = 1'b0, aresetn = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, cpu_wt = 1'b0;
  logic cpu_ci = 1'b0, cpu_coh = 1'b1, snp_valid = 1'b0, snp_inv = 1'b0, sh_in = 1'b0;
  logic [31:0] cpu_addr = '0, cpu_wdata = '0, snp_addr = '0, cpu_rdata, bus_addr, got, wb_lane;
  logic cpu_ready, cpu_rvalid, bus_req, bus_ack, bus_shared, snp_ready, snp_hit, snp_dirty;
  logic [1:0] bus_cmd, s_axi_bresp, s_axi_rresp, rsp;
  logic [127:0] bus_wdata, bus_rdata;
  logic [3:0] dly = 4'h0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  int mismatches = 0, samples_checked = 0, wr_n = 0, w0;
  cmc_cache cmc_cache_inst (.aclk, .aresetn, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata,
    .cpu_wt, .cpu_ci, .cpu_coh, .cpu_ready, .cpu_rvalid, .cpu_rdata, .bus_req, .bus_cmd,
    .bus_addr, .bus_wdata, .bus_ack, .bus_rdata, .bus_shared, .snp_valid, .snp_addr, .snp_inv,
    .snp_ready, .snp_hit, .snp_dirty, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  cmc_bus_mem cmc_bus_mem_inst (.aclk, .aresetn, .bus_req, .bus_cmd, .bus_addr, .bus_wdata,
    .dly, .sh_in, .bus_ack, .bus_rdata, .bus_shared);
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (bus_ack && bus_req && bus_cmd == BUS_WR) wr_n <= wr_n + 1;
    if (bus_ack && bus_cmd == BUS_WR && bus_addr == 32'h1030) wb_lane <= bus_wdata[95:64];
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] pat(logic [31:0] a);
    return a ^ 32'hc3c30000;
  endfunction
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_v(ref logic s, input logic v);
    int n;
    n = 0;
    #1;
    while (s !== v) begin
      @(posedge aclk);
      #1;
      n++;
      if (n > 400) begin
        check("wait", 32'h0, 32'h1);
        report_and_stop();
      end
    end
  endtask
  task automatic axw(logic [4:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    wait_v(s_axi_awready, 1'b1);
    wait_v(s_axi_wready, 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_v(s_axi_bvalid, 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(logic [4:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    wait_v(s_axi_arready, 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    wait_v(s_axi_rvalid, 1'b1);
    check("rresp", s_axi_rresp, er);
    if (er == CMC_RESP_OKAY) check("rdata", s_axi_rdata, e);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic cpu(logic we, wt, ci, logic [31:0] a, d);
    @(posedge aclk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_wt <= wt;
    cpu_ci <= ci;
    cpu_addr <= a;
    cpu_wdata <= d;
    wait_v(cpu_ready, 1'b1);
    @(posedge aclk);
    cpu_req <= 1'b0;
    #1;
    got = cpu_rdata;
    check("rvalid", cpu_rvalid, 32'(!we));
  endtask
  task automatic ld(logic [31:0] a, e);
    cpu(1'b0, 1'b0, 1'b0, a, 32'h0);
    check("load", got, e);
  endtask
  task automatic snoop(logic [31:0] a, logic inv, logic eh, ed);
    @(posedge aclk);
    snp_valid <= 1'b1;
    snp_addr <= a;
    snp_inv <= inv;
    wait_v(snp_ready, 1'b1);
    @(posedge aclk);
    snp_valid <= 1'b0;
    snp_addr <= ~a;
    #1;
    check("snp_hit", snp_hit, eh);
    check("snp_dirty", snp_dirty, ed);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(CMC_REG_CTRL, 32'h0, CMC_RESP_OKAY);
    rchk(CMC_REG_MISSES, 32'h0, CMC_RESP_OKAY);
    rchk(5'h10, 32'h0, CMC_RESP_SLVERR);
    axw(5'h14, 32'h1);
    check("bresp", rsp, CMC_RESP_SLVERR);
    snoop(32'h5000, 1'b0, 1'b0, 1'b0);
    ld(32'h1038, pat(32'h1038));
    wait_v(bus_req, 1'b0);
    ld(32'h1024, pat(32'h1024));
    ld(32'h1004, pat(32'h1004));
    rchk(CMC_REG_HITS, 32'h2, CMC_RESP_OKAY);
    axw(CMC_REG_CTRL, 32'h1);
    ld(32'h2020, pat(32'h2020));
    wait_v(bus_req, 1'b0);
    ld(32'h2000, pat(32'h2000));
    axw(CMC_REG_CTRL, 32'h0);
    cpu(1'b1, 1'b0, 1'b0, 32'h1038, 32'h5eed0001);
    ld(32'h1038, 32'h5eed0001);
    snoop(32'h1038, 1'b0, 1'b1, 1'b1);
    wait_v(bus_req, 1'b0);
    check("writeback", wb_lane, 32'h5eed0001);
    snoop(32'h1038, 1'b1, 1'b1, 1'b0);
    ld(32'h1038, 32'h5eed0001);
    wait_v(bus_req, 1'b0);
    cpu(1'b0, 1'b0, 1'b1, 32'h3004, 32'h0);
    check("inhibited", got, pat(32'h3004));
    ld(32'h3004, pat(32'h3004));
    wait_v(bus_req, 1'b0);
    cpu(1'b1, 1'b1, 1'b0, 32'h1010, 32'h1234abcd);
    ld(32'h1010, 32'h1234abcd);
    sh_in <= 1'b1;
    ld(32'h4000, pat(32'h4000));
    wait_v(bus_req, 1'b0);
    w0 = wr_n;
    cpu(1'b1, 1'b0, 1'b0, 32'h4000, 32'h77);
    wait_v(bus_req, 1'b0);
    check("shared store", 32'(wr_n - w0), 32'h1);
    sh_in <= 1'b0;
    cpu(1'b1, 1'b0, 1'b0, 32'h5008, 32'habcd0123);
    ld(32'h5008, 32'habcd0123);
    dly <= 4'h3;
    for (int k = 0; k < 8; k++) begin
      ld(32'(k << 12) | 32'h40, pat(32'(k << 12) | 32'h40));
      wait_v(bus_req, 1'b0);
    end
    ld(32'h40, pat(32'h40));
    ld(32'h8040, pat(32'h8040));
    wait_v(bus_req, 1'b0);
    ld(32'h40, pat(32'h40));
    ld(32'h1040, pat(32'h1040));
    rchk(CMC_REG_HITS, 32'ha, CMC_RESP_OKAY);
    rchk(CMC_REG_MISSES, 32'h11, CMC_RESP_OKAY);
    report_and_stop();
  end
endmodule
